// *** bench/ssd_decoder_sva.sv ***
// port-level checker for the special register space decoder
`timescale 1ns/10ps
`default_nettype none
module ssd_decoder_chk
  import ssd_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register space access
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_rd,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_rvalid,
  // register file view
  input wire ssd_pkg::ssd_rfsel_t rf_sel,
  input wire logic rf_rd,
  input wire logic rf_wr,
  input wire logic [7:0] rf_wdata,
  input wire logic rf_rvalid,
  // far side
  input wire logic [7:0] usb_rx_data,
  input wire logic usb_rx_pop,
  input wire logic [7:0] usb_tx_data,
  input wire logic usb_tx_push,
  input wire logic periph_wr,
  input wire logic [7:0] periph_addr,
  input wire logic [7:0] periph_wdata,
  // held values
  input wire logic [7:0] port0_out,
  input wire logic [7:0] accumulator_byte,
  input wire logic [15:0] stack_pointer,
  input wire logic [23:0] data_pointer
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // read answers: exact latency, and never unasked
  chk_read_answer: assert property (sfr_rd |-> ##2 sfr_rvalid)
    else $error("read not answered two cycles on");
  chk_no_stray: assert property (sfr_rvalid |-> $past(sfr_rd, 2))
    else $error("read answer without a request");
  chk_rf_answer: assert property (rf_rd |=> rf_rvalid)
    else $error("register file read not answered");
  // writes below the space leave port 0, the accumulator and peripheral storage alone
  chk_unimpl_quiet: assert property (sfr_wr && sfr_addr < 8'h80 && !rf_wr
    |=> !periph_wr && $stable(port0_out) && $stable(accumulator_byte))
    else $error("write to unimplemented place had an effect");
  chk_timer_map: assert property (sfr_wr && sfr_addr inside {[8'h8a:8'h8d]}
    |=> periph_wr && periph_addr == $past(sfr_addr)
    && periph_wdata == $past(sfr_wdata))
    else $error("timer byte write not passed on");
  chk_cmp_map: assert property (sfr_wr
    && sfr_addr inside {[8'hea:8'hee], [8'hfa:8'hfe], 8'hf2}
    |=> periph_wr && periph_addr == $past(sfr_addr))
    else $error("compare or status write not passed on");
  chk_rx_route: assert property (sfr_rd && sfr_addr == 8'he3
    |=> usb_rx_pop ##1 sfr_rdata == $past(usb_rx_data, 2))
    else $error("receive port read misrouted");
  chk_tx_route: assert property (sfr_wr && sfr_addr == 8'hf3
    |=> usb_tx_push && usb_tx_data == $past(sfr_wdata))
    else $error("transmit port write misrouted");
  chk_reset_load: assert property ($fell(rst) |-> port0_out == 8'hff
    && stack_pointer == 16'h0007 && data_pointer == 24'h010000)
    else $error("wrong value after reset");
  chk_acc_shared: assert property (rf_wr && rf_sel == RF_ACC
    |=> accumulator_byte == $past(rf_wdata))
    else $error("accumulator not shared with register file");
endmodule : ssd_decoder_chk
bind ssd_decoder ssd_decoder_chk chk_u (.core_clk, .rst, .sfr_addr,
  .sfr_rd, .sfr_wr, .sfr_wdata, .sfr_rdata, .sfr_rvalid, .rf_sel, .rf_rd,
  .rf_wr, .rf_wdata, .rf_rvalid, .usb_rx_data, .usb_rx_pop, .usb_tx_data,
  .usb_tx_push, .periph_wr, .periph_addr, .periph_wdata, .port0_out,
  .accumulator_byte, .stack_pointer, .data_pointer);
`default_nettype wire

// *** bench/ssd_decoder_test.sv ***
// self-checking bench for the special register space decoder
`timescale 1ns/10ps
`default_nettype none
module ssd_decoder_test;
  import ssd_pkg::*;
  logic core_clk, rst, sfr_rd, sfr_wr, rf_rd, rf_wr, sfr_rvalid, rf_rvalid;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rf_wdata, rf_rdata, d;
  logic usb_rx_pop, usb_tx_push, periph_wr;
  logic [7:0] usb_rx_data, usb_tx_data, periph_addr, periph_wdata;
  logic [7:0] port0_out, port1_out, port2_out, port3_out;
  logic [7:0] accumulator_byte, mult_b_byte;
  logic [15:0] stack_pointer;
  logic [23:0] data_pointer;
  ssd_rfsel_t rf_sel;
  int failures = 0;
  int total_checks = 0;
  // flop-held and memory-held places, then places with no storage
  logic [7:0] rw_addr [61] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h90,
    8'ha0, 8'hb0, 8'hbe, 8'he0, 8'hf0, 8'h87, 8'h88, 8'h89, 8'h8a, 8'h8b,
    8'h8c, 8'h8d, 8'h8f, 8'h98, 8'h99, 8'ha2, 8'ha6, 8'ha7, 8'ha8, 8'ha9,
    8'hb1, 8'hb2, 8'hb3, 8'hb7, 8'hb8, 8'hb9, 8'hc0, 8'hc8, 8'hc9, 8'hca,
    8'hcb, 8'hcc, 8'hcd, 8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd8, 8'hd9, 8'hda,
    8'hdb, 8'hdc, 8'hdd, 8'hde, 8'hea, 8'heb, 8'hec, 8'hed, 8'hee, 8'hf2,
    8'hfa, 8'hfb, 8'hfc, 8'hfd, 8'hfe};
  logic [7:0] bad_addr [9] = '{8'h00, 8'h7f, 8'h7a, 8'h0a, 8'he1, 8'he9,
    8'hf9, 8'hff, 8'hdf};
  logic [7:0] rf_addr [7] = '{8'he0, 8'hf0, 8'h81, 8'hbe, 8'h82, 8'h83,
    8'h84};
  logic [7:0] rst_val [11] = '{8'hff, 8'h07, 8'h00, 8'h00, 8'h01, 8'hff,
    8'hff, 8'hff, 8'h00, 8'h00, 8'h00};

  ssd_decoder dut_u (.core_clk, .rst, .sfr_addr, .sfr_rd, .sfr_wr,
    .sfr_wdata, .sfr_rdata, .sfr_rvalid, .rf_sel, .rf_rd, .rf_wr, .rf_wdata,
    .rf_rdata, .rf_rvalid, .usb_rx_data, .usb_rx_pop, .usb_tx_data,
    .usb_tx_push, .periph_wr, .periph_addr, .periph_wdata, .port0_out,
    .port1_out, .port2_out, .port3_out, .accumulator_byte, .mult_b_byte,
    .stack_pointer, .data_pointer);
  ssd_usb_model usb_u (.core_clk, .rst, .usb_rx_pop, .usb_rx_data,
    .usb_tx_push, .usb_tx_data);

  // 20 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  // one byte write, request held for exactly one taking edge
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= v;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
  endtask : sfr_write

  // answer comes two edges after the taking edge
  task automatic sfr_read(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    sfr_rd <= 1'b1;
    sfr_addr <= a;
    @(posedge core_clk);
    sfr_rd <= 1'b0;
    repeat (2) @(posedge core_clk);
    check({7'h00, sfr_rvalid}, 8'h01);
    v = sfr_rdata;
  endtask : sfr_read

  task automatic rf_write(input ssd_rfsel_t s, input logic [7:0] v);
    @(posedge core_clk);
    rf_wr <= 1'b1;
    rf_sel <= s;
    rf_wdata <= v;
    @(posedge core_clk);
    rf_wr <= 1'b0;
  endtask : rf_write

  task automatic rf_read(input ssd_rfsel_t s, output logic [7:0] v);
    @(posedge core_clk);
    rf_rd <= 1'b1;
    rf_sel <= s;
    @(posedge core_clk);
    rf_rd <= 1'b0;
    @(posedge core_clk);
    check({7'h00, rf_rvalid}, 8'h01);
    v = rf_rdata;
  endtask : rf_read

  // reset for 16 cycles, then look at pins and the dedicated bytes
  task automatic reset_and_check;
    logic [7:0] v;
    rst <= 1'b1;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    check(port3_out, 8'hff);
    check(port1_out, 8'hff);
    check(port2_out, 8'hff);
    check(data_pointer[23:16], 8'h01);
    for (int i = 0; i < 11; i++) begin
      sfr_read(rw_addr[i], v);
      check(v, rst_val[i]);
    end
    sfr_read(8'hd8, v);
    check(v, 8'h00);
  endtask : reset_and_check

  // hang guard, far beyond the under a thousand cycles the run needs
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    wrap_up();
  end

  initial begin
    rst = 1'b1;
    {sfr_rd, sfr_wr, rf_rd, rf_wr} = 4'h0;
    {sfr_addr, sfr_wdata, rf_wdata} = 24'h000000;
    rf_sel = RF_ACC;
    reset_and_check();
    // fill every place first so aliasing between places shows on read
    foreach (rw_addr[i]) sfr_write(rw_addr[i], rw_addr[i] ^ 8'h5c);
    for (int p = 0; p < 2; p++) begin
      foreach (rw_addr[i]) begin
        sfr_read(rw_addr[i], d);
        check(d, rw_addr[i] ^ 8'h5c);
      end
      // value read back from empty places is not defined, so unchecked
      foreach (bad_addr[i]) begin
        sfr_write(bad_addr[i], 8'hee);
        sfr_read(bad_addr[i], d);
      end
    end
    // dedicated bytes seen the same through both views
    foreach (rf_addr[i]) begin
      rf_write(ssd_rfsel_t'(i), 8'h40 + 8'(i));
      sfr_read(rf_addr[i], d);
      check(d, 8'h40 + 8'(i));
      sfr_write(rf_addr[i], 8'hc0 + 8'(i));
      rf_read(ssd_rfsel_t'(i), d);
      check(d, 8'hc0 + 8'(i));
    end
    check(stack_pointer[15:8], 8'hc3);
    check(data_pointer[23:16], 8'hc6);
    check(mult_b_byte, 8'hc1);
    // fifo ports: wrong-direction accesses must not move either fifo
    sfr_write(8'he3, 8'h99);
    sfr_read(8'hf3, d);
    sfr_read(8'he3, d);
    check(d, 8'h5a);
    sfr_read(8'he3, d);
    check(d, 8'h6b);
    sfr_write(8'hf3, 8'ha1);
    sfr_write(8'hf3, 8'hb2);
    repeat (2) @(posedge core_clk);
    check(usb_u.rx_cnt, 8'h02);
    check({5'h00, usb_u.tx_cnt}, 8'h02);
    check(usb_u.tx_log[0], 8'ha1);
    check(usb_u.tx_log[1], 8'hb2);
    // second reset in mid-run restores the mapped values
    reset_and_check();
    wrap_up();
  end
endmodule : ssd_decoder_test
`default_nettype wire

// *** bench/ssd_usb_model.sv ***
// far side usb fifo model: receive head byte and transmit log
`timescale 1ns/10ps
`default_nettype none
module ssd_usb_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // receive fifo side
  input wire logic usb_rx_pop,
  output logic [7:0] usb_rx_data,
  // transmit fifo side
  input wire logic usb_tx_push,
  input wire logic [7:0] usb_tx_data
);
  logic [7:0] rx_cnt;
  logic [2:0] tx_cnt;
  logic [7:0] tx_log [0:7];
  // head walks a known sequence so a missed or extra pop shows up
  assign usb_rx_data = 8'h5a + rx_cnt * 8'h11;
  // advance on each pop, log each push
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_cnt <= 8'h00;
      tx_cnt <= 3'h0;
    end else begin
      if (usb_rx_pop) rx_cnt <= rx_cnt + 8'h01;
      if (usb_tx_push) begin
        tx_log[tx_cnt] <= usb_tx_data;
        tx_cnt <= tx_cnt + 3'h1;
      end
    end
  end
endmodule : ssd_usb_model
`default_nettype wire

// *** design/ssd_decoder.sv ***
// special register space decoder with shared dedicated core registers
//
// Summary of operation
// R1: outside 80..ff or unassigned: no storage
// R2: writes to unimplemented locations change nothing
// R3: reads of unimplemented locations complete, value undefined
// R4: byte accesses only, no multi-byte transfers
// R5: reset loads each register's mapped value
// R6: dedicated bytes shared with core register file
// R7: timer count bytes at 8a..8d, interleaved
// R8: compare low bytes from ea, highs from fa
// R9: e3 is receive fifo, f3 transmit fifo
// R10: transmit status at f2, fa stays compare
`timescale 1ns/10ps
`default_nettype none
module ssd_decoder
  import ssd_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // core byte access to the register space
  input wire logic [ssd_pkg::ADDR_W-1:0] sfr_addr,
  input wire logic sfr_rd,
  input wire logic sfr_wr,
  input wire logic [ssd_pkg::DATA_W-1:0] sfr_wdata,
  output logic [ssd_pkg::DATA_W-1:0] sfr_rdata,
  output logic sfr_rvalid,
  // core register file view of the dedicated bytes
  input wire ssd_pkg::ssd_rfsel_t rf_sel,
  input wire logic rf_rd,
  input wire logic rf_wr,
  input wire logic [ssd_pkg::DATA_W-1:0] rf_wdata,
  output logic [ssd_pkg::DATA_W-1:0] rf_rdata,
  output logic rf_rvalid,
  // usb fifo data ports
  input wire logic [ssd_pkg::DATA_W-1:0] usb_rx_data,
  output logic usb_rx_pop,
  output logic [ssd_pkg::DATA_W-1:0] usb_tx_data,
  output logic usb_tx_push,
  // write notice to peripheral storage
  output logic periph_wr,
  output logic [ssd_pkg::ADDR_W-1:0] periph_addr,
  output logic [ssd_pkg::DATA_W-1:0] periph_wdata,
  // port latches
  output logic [ssd_pkg::DATA_W-1:0] port0_out,
  output logic [ssd_pkg::DATA_W-1:0] port1_out,
  output logic [ssd_pkg::DATA_W-1:0] port2_out,
  output logic [ssd_pkg::DATA_W-1:0] port3_out,
  // dedicated register values for the core
  output logic [ssd_pkg::DATA_W-1:0] accumulator_byte,
  output logic [ssd_pkg::DATA_W-1:0] mult_b_byte,
  output logic [15:0] stack_pointer,
  output logic [23:0] data_pointer
);

  // map an address onto a memory slot; bit 6 flags a hit
  function automatic logic [6:0] mem_slot(input logic [7:0] a);
    logic [7:0] off;
    off = 8'h00;
    mem_slot = 7'h00; // R1
    if (a < ADDR_SPACE_LO) mem_slot = 7'h00; // R1
    else if (a == ADDR_POWER_CTRL) mem_slot = 7'h40;
    else if (a == ADDR_TMR01_CTRL) mem_slot = 7'h41;
    else if (a == ADDR_TMR01_MODE) mem_slot = 7'h42;
    else if (a == ADDR_TMR0_LOW) mem_slot = 7'h43; // R7
    else if (a == ADDR_TMR1_LOW) mem_slot = 7'h44; // R7
    else if (a == ADDR_TMR0_HIGH) mem_slot = 7'h45; // R7
    else if (a == ADDR_TMR1_HIGH) mem_slot = 7'h46; // R7
    else if (a == ADDR_USB_FUNC_ADR) mem_slot = 7'h47;
    else if (a == ADDR_SER_CTRL) mem_slot = 7'h48;
    else if (a == ADDR_SER_BUF) mem_slot = 7'h49;
    else if (a == ADDR_USB_IRQ_EN) mem_slot = 7'h4a;
    else if (a == ADDR_WDOG_RESTART) mem_slot = 7'h4b;
    else if (a == ADDR_WDOG_CONFIG) mem_slot = 7'h4c;
    else if (a == ADDR_IRQ_EN0) mem_slot = 7'h4d;
    else if (a == ADDR_SER_SLAVE) mem_slot = 7'h4e;
    else if (a == ADDR_IRQ_EN1) mem_slot = 7'h4f;
    else if (a == ADDR_IRQ_PRL1) mem_slot = 7'h50;
    else if (a == ADDR_IRQ_PRH1) mem_slot = 7'h51;
    else if (a == ADDR_IRQ_PRH0) mem_slot = 7'h52;
    else if (a == ADDR_IRQ_PRL0) mem_slot = 7'h53;
    else if (a == ADDR_SER_SMASK) mem_slot = 7'h54;
    else if (a == ADDR_USB_IRQ_FLG) mem_slot = 7'h55;
    else if (a == ADDR_TMR2_CTRL) mem_slot = 7'h56;
    else if (a == ADDR_TMR2_MODE) mem_slot = 7'h57;
    else if (a == ADDR_TMR2_RLD_LOW) mem_slot = 7'h58;
    else if (a == ADDR_TMR2_RLD_HIGH) mem_slot = 7'h59;
    else if (a == ADDR_TMR2_LOW) mem_slot = 7'h5a;
    else if (a == ADDR_TMR2_HIGH) mem_slot = 7'h5b;
    else if (a == ADDR_PSTAT) mem_slot = 7'h5c;
    else if (a == ADDR_PSTAT1) mem_slot = 7'h5d;
    else if (a == ADDR_FRAME_LOW) mem_slot = 7'h5e;
    else if (a == ADDR_FRAME_HIGH) mem_slot = 7'h5f;
    else if (a == ADDR_CARRAY_CTRL) mem_slot = 7'h60;
    else if (a == ADDR_CARRAY_MODE) mem_slot = 7'h61;
    else if (a == ADDR_EP_TX_STATUS) begin
      mem_slot = {1'b1, SLOT_EP_TX_STATUS}; // R10
    end else if (a >= ADDR_CMP_MODE0 && a < ADDR_CMP_MODE0 + CMP_MODULES) begin
      off = a - ADDR_CMP_MODE0;
      mem_slot = {1'b1, SLOT_CMP_MODE0 + off[5:0]};
    end else if (a >= ADDR_CMP_LOW0 && a < ADDR_CMP_LOW0 + CMP_MODULES) begin
      off = a - ADDR_CMP_LOW0;
      mem_slot = {1'b1, SLOT_CMP_LOW0 + off[5:0]}; // R8
    end else if (a >= ADDR_CMP_HIGH0 && a < ADDR_CMP_HIGH0 + CMP_MODULES) begin
      off = a - ADDR_CMP_HIGH0;
      mem_slot = {1'b1, SLOT_CMP_HIGH0 + off[5:0]}; // R8
    end
  endfunction : mem_slot

  // next value of a shared byte; the register file wins a collision
  // since the core's own pipeline owns those writes
  function automatic logic [7:0] shared_next(
    input logic [7:0] cur,
    input logic sfr_hit,
    input logic rf_hit
  );
    if (rf_hit) begin
      shared_next = rf_wdata;
    end else if (sfr_hit) begin
      shared_next = sfr_wdata;
    end else begin
      shared_next = cur;
    end
  endfunction : shared_next

  // dedicated and port latch storage
  logic [7:0] port0_r;
  logic [7:0] port1_r;
  logic [7:0] port2_r;
  logic [7:0] port3_r;
  logic [7:0] acc_r;
  logic [7:0] mult_b_r;
  logic [7:0] sp_low_r;
  logic [7:0] sp_high_r;
  logic [7:0] dp_low_r;
  logic [7:0] dp_high_r;
  logic [7:0] dp_ext_r;

  // decode of the current request
  logic [6:0] slot_hit;
  logic mem_hit;
  logic mem_wr;
  logic mem_rd;
  logic rx_hit;
  logic tx_hit;
  logic ded_hit;
  logic [7:0] ded_val;
  logic [7:0] mem_rdata;

  // read pipeline
  logic rd_p1_r;
  logic mem_p1_r;
  logic [7:0] local_p1_r;

  assign slot_hit = mem_slot(sfr_addr);
  assign mem_hit = slot_hit[6];
  // a byte write to a mapped slot is the only path into the register memory
  assign mem_wr = sfr_wr && mem_hit; // R2 R4
  assign mem_rd = sfr_rd && mem_hit;
  assign rx_hit = (sfr_addr == ADDR_USB_RX_FIFO); // R9
  assign tx_hit = (sfr_addr == ADDR_USB_TX_FIFO); // R9

  // read value and hit flag of the dedicated and latch bytes
  always_comb begin
    ded_hit = 1'b1;
    ded_val = RD_UNIMPL;
    if (sfr_addr == ADDR_PORT0) begin
      ded_val = port0_r;
    end else if (sfr_addr == ADDR_SP_LOW) begin
      ded_val = sp_low_r;
    end else if (sfr_addr == ADDR_DP_LOW) begin
      ded_val = dp_low_r;
    end else if (sfr_addr == ADDR_DP_HIGH) begin
      ded_val = dp_high_r;
    end else if (sfr_addr == ADDR_DP_EXT) begin
      ded_val = dp_ext_r;
    end else if (sfr_addr == ADDR_PORT1) begin
      ded_val = port1_r;
    end else if (sfr_addr == ADDR_PORT2) begin
      ded_val = port2_r;
    end else if (sfr_addr == ADDR_PORT3) begin
      ded_val = port3_r;
    end else if (sfr_addr == ADDR_SP_HIGH) begin
      ded_val = sp_high_r;
    end else if (sfr_addr == ADDR_ACC) begin
      ded_val = acc_r; // R6
    end else if (sfr_addr == ADDR_MULT_B) begin
      ded_val = mult_b_r; // R6
    end else begin
      ded_hit = 1'b0;
    end
  end

  // port latches come up all ones so the pins idle high
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      port0_r <= RST_PORT; // R5
      port1_r <= RST_PORT; // R5
      port2_r <= RST_PORT; // R5
      port3_r <= RST_PORT; // R5
    end else if (sfr_wr) begin
      if (sfr_addr == ADDR_PORT0) begin
        port0_r <= sfr_wdata;
      end else if (sfr_addr == ADDR_PORT1) begin
        port1_r <= sfr_wdata;
      end else if (sfr_addr == ADDR_PORT2) begin
        port2_r <= sfr_wdata;
      end else if (sfr_addr == ADDR_PORT3) begin
        port3_r <= sfr_wdata;
      end
    end
  end

  // accumulator and multiplier byte, one storage for both views
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      acc_r <= RST_ZERO; // R5
      mult_b_r <= RST_ZERO; // R5
    end else begin
      acc_r <= shared_next(acc_r, sfr_wr && sfr_addr == ADDR_ACC,
        rf_wr && rf_sel == RF_ACC); // R6
      mult_b_r <= shared_next(mult_b_r, sfr_wr && sfr_addr == ADDR_MULT_B,
        rf_wr && rf_sel == RF_MULT_B); // R6
    end
  end

  // stack pointer bytes; low byte starts at 07
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sp_low_r <= RST_SP_LOW; // R5
      sp_high_r <= RST_ZERO; // R5
    end else begin
      sp_low_r <= shared_next(sp_low_r, sfr_wr && sfr_addr == ADDR_SP_LOW,
        rf_wr && rf_sel == RF_SP_LOW); // R6
      sp_high_r <= shared_next(sp_high_r, sfr_wr && sfr_addr == ADDR_SP_HIGH,
        rf_wr && rf_sel == RF_SP_HIGH); // R6
    end
  end

  // data pointer bytes; the extended byte starts at region 01
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dp_low_r <= RST_ZERO; // R5
      dp_high_r <= RST_ZERO; // R5
      dp_ext_r <= RST_DP_EXT; // R5
    end else begin
      dp_low_r <= shared_next(dp_low_r, sfr_wr && sfr_addr == ADDR_DP_LOW,
        rf_wr && rf_sel == RF_DP_LOW); // R6
      dp_high_r <= shared_next(dp_high_r, sfr_wr && sfr_addr == ADDR_DP_HIGH,
        rf_wr && rf_sel == RF_DP_HIGH); // R6
      dp_ext_r <= shared_next(dp_ext_r, sfr_wr && sfr_addr == ADDR_DP_EXT,
        rf_wr && rf_sel == RF_DP_EXT); // R6
    end
  end

  // plain peripheral registers
  ssd_regmem u_regmem (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(mem_wr),
    .wr_slot(slot_hit[5:0]),
    .wr_data(sfr_wdata),
    .rd_en(mem_rd),
    .rd_slot(slot_hit[5:0]),
    .rd_data(mem_rdata)
  );

  // read stage one: note the source, capture local data
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_p1_r <= 1'b0;
      mem_p1_r <= 1'b0;
      local_p1_r <= RST_ZERO;
    end else begin
      rd_p1_r <= sfr_rd;
      mem_p1_r <= mem_rd;
      if (sfr_rd) begin
        if (ded_hit) begin
          local_p1_r <= ded_val;
        end else if (rx_hit) begin
          local_p1_r <= usb_rx_data; // R9
        end else begin
          local_p1_r <= RD_UNIMPL; // R3
        end
      end
    end
  end

  // read stage two: every read answers, mapped or not
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sfr_rvalid <= 1'b0;
      sfr_rdata <= RST_ZERO;
    end else begin
      sfr_rvalid <= rd_p1_r; // R3
      if (rd_p1_r) begin
        sfr_rdata <= mem_p1_r ? mem_rdata : local_p1_r;
      end
    end
  end

  // register file read of the dedicated bytes, one cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rf_rvalid <= 1'b0;
      rf_rdata <= RST_ZERO;
    end else begin
      rf_rvalid <= rf_rd;
      if (rf_rd) begin
        case (rf_sel)
          RF_ACC: rf_rdata <= acc_r; // R6
          RF_MULT_B: rf_rdata <= mult_b_r;
          RF_SP_LOW: rf_rdata <= sp_low_r;
          RF_SP_HIGH: rf_rdata <= sp_high_r;
          RF_DP_LOW: rf_rdata <= dp_low_r;
          RF_DP_HIGH: rf_rdata <= dp_high_r;
          RF_DP_EXT: rf_rdata <= dp_ext_r;
          default: rf_rdata <= RD_UNIMPL;
        endcase
      end
    end
  end

  // fifo strobes; a read of the receive port pops exactly one byte
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      usb_rx_pop <= 1'b0;
      usb_tx_push <= 1'b0;
      usb_tx_data <= RST_ZERO;
    end else begin
      usb_rx_pop <= sfr_rd && rx_hit; // R9
      usb_tx_push <= sfr_wr && tx_hit; // R9
      if (sfr_wr && tx_hit) begin
        usb_tx_data <= sfr_wdata;
      end
    end
  end

  // tell peripheral storage about every write to a memory-held register;
  // unmapped writes raise no notice at all
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      periph_wr <= 1'b0;
      periph_addr <= RST_ZERO;
      periph_wdata <= RST_ZERO;
    end else begin
      periph_wr <= mem_wr; // R2
      if (mem_wr) begin
        periph_addr <= sfr_addr;
        periph_wdata <= sfr_wdata;
      end
    end
  end

  // outputs straight from the storage flops
  assign port0_out = port0_r;
  assign port1_out = port1_r;
  assign port2_out = port2_r;
  assign port3_out = port3_r;
  assign accumulator_byte = acc_r;
  assign mult_b_byte = mult_b_r;
  assign stack_pointer = {sp_high_r, sp_low_r};
  assign data_pointer = {dp_ext_r, dp_high_r, dp_low_r};

endmodule : ssd_decoder
`default_nettype wire

// *** design/ssd_regmem.sv ***
// register memory for the plain peripheral registers, registered read
`timescale 1ns/10ps
`default_nettype none
module ssd_regmem
  import ssd_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // write port
  input wire logic wr_en,
  input wire logic [ssd_pkg::SLOT_W-1:0] wr_slot,
  input wire logic [ssd_pkg::DATA_W-1:0] wr_data,
  // read port
  input wire logic rd_en,
  input wire logic [ssd_pkg::SLOT_W-1:0] rd_slot,
  output logic [ssd_pkg::DATA_W-1:0] rd_data
);

  logic [DATA_W-1:0] mem_r [MEM_DEPTH];

  // every held register clears at reset; all of them reset to zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_r[i] <= RST_ZERO;
      end
    end else if (wr_en) begin
      mem_r[wr_slot] <= wr_data;
    end
  end

  // read data leaves from a register, one cycle after the request
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_data <= RST_ZERO;
    end else if (rd_en) begin
      rd_data <= mem_r[rd_slot]; // old value on a same-cycle write
    end
  end

endmodule : ssd_regmem
`default_nettype wire

// *** pkg/ssd_pkg.sv ***
// constants and types shared by the special register space decoder
`default_nettype none
package ssd_pkg;

  // access widths: the space is strictly byte wide
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int SLOT_W = 6;
  localparam int MEM_DEPTH = 64;

  // lowest implemented address of the space
  localparam logic [7:0] ADDR_SPACE_LO = 8'h80;

  // port latches and dedicated registers; all but the ports shared with the core register file
  localparam logic [7:0] ADDR_PORT0 = 8'h80;
  localparam logic [7:0] ADDR_SP_LOW = 8'h81;
  localparam logic [7:0] ADDR_DP_LOW = 8'h82;
  localparam logic [7:0] ADDR_DP_HIGH = 8'h83;
  localparam logic [7:0] ADDR_DP_EXT = 8'h84;
  localparam logic [7:0] ADDR_PORT1 = 8'h90;
  localparam logic [7:0] ADDR_PORT2 = 8'ha0;
  localparam logic [7:0] ADDR_PORT3 = 8'hb0;
  localparam logic [7:0] ADDR_SP_HIGH = 8'hbe;
  localparam logic [7:0] ADDR_ACC = 8'he0;
  localparam logic [7:0] ADDR_MULT_B = 8'hf0;

  // usb fifo data ports, no storage here
  localparam logic [7:0] ADDR_USB_RX_FIFO = 8'he3;
  localparam logic [7:0] ADDR_USB_TX_FIFO = 8'hf3;

  // plain peripheral registers held in the register memory
  localparam logic [7:0] ADDR_POWER_CTRL = 8'h87;
  localparam logic [7:0] ADDR_TMR01_CTRL = 8'h88;
  localparam logic [7:0] ADDR_TMR01_MODE = 8'h89;
  localparam logic [7:0] ADDR_TMR0_LOW = 8'h8a;
  localparam logic [7:0] ADDR_TMR1_LOW = 8'h8b;
  localparam logic [7:0] ADDR_TMR0_HIGH = 8'h8c;
  localparam logic [7:0] ADDR_TMR1_HIGH = 8'h8d;
  localparam logic [7:0] ADDR_USB_FUNC_ADR = 8'h8f;
  localparam logic [7:0] ADDR_SER_CTRL = 8'h98;
  localparam logic [7:0] ADDR_SER_BUF = 8'h99;
  localparam logic [7:0] ADDR_USB_IRQ_EN = 8'ha2;
  localparam logic [7:0] ADDR_WDOG_RESTART = 8'ha6;
  localparam logic [7:0] ADDR_WDOG_CONFIG = 8'ha7;
  localparam logic [7:0] ADDR_IRQ_EN0 = 8'ha8;
  localparam logic [7:0] ADDR_SER_SLAVE = 8'ha9;
  localparam logic [7:0] ADDR_IRQ_EN1 = 8'hb1;
  localparam logic [7:0] ADDR_IRQ_PRL1 = 8'hb2;
  localparam logic [7:0] ADDR_IRQ_PRH1 = 8'hb3;
  localparam logic [7:0] ADDR_IRQ_PRH0 = 8'hb7;
  localparam logic [7:0] ADDR_IRQ_PRL0 = 8'hb8;
  localparam logic [7:0] ADDR_SER_SMASK = 8'hb9;
  localparam logic [7:0] ADDR_USB_IRQ_FLG = 8'hc0;
  localparam logic [7:0] ADDR_TMR2_CTRL = 8'hc8;
  localparam logic [7:0] ADDR_TMR2_MODE = 8'hc9;
  localparam logic [7:0] ADDR_TMR2_RLD_LOW = 8'hca;
  localparam logic [7:0] ADDR_TMR2_RLD_HIGH = 8'hcb;
  localparam logic [7:0] ADDR_TMR2_LOW = 8'hcc;
  localparam logic [7:0] ADDR_TMR2_HIGH = 8'hcd;
  localparam logic [7:0] ADDR_PSTAT = 8'hd0;
  localparam logic [7:0] ADDR_PSTAT1 = 8'hd1;
  localparam logic [7:0] ADDR_FRAME_LOW = 8'hd2;
  localparam logic [7:0] ADDR_FRAME_HIGH = 8'hd3;
  localparam logic [7:0] ADDR_CARRAY_CTRL = 8'hd8;
  localparam logic [7:0] ADDR_CARRAY_MODE = 8'hd9;
  localparam logic [7:0] ADDR_CMP_MODE0 = 8'hda;
  localparam logic [7:0] ADDR_EP_TX_STATUS = 8'hf2;
  localparam logic [7:0] ADDR_CMP_LOW0 = 8'hea;
  localparam logic [7:0] ADDR_CMP_HIGH0 = 8'hfa;
  localparam logic [7:0] CMP_MODULES = 8'h05;

  // memory slots for the ranged groups and the transmit status
  localparam logic [5:0] SLOT_CMP_MODE0 = 6'h22;
  localparam logic [5:0] SLOT_CMP_LOW0 = 6'h27;
  localparam logic [5:0] SLOT_CMP_HIGH0 = 6'h2c;
  localparam logic [5:0] SLOT_EP_TX_STATUS = 6'h31;

  // reset values
  localparam logic [7:0] RST_PORT = 8'hff;
  localparam logic [7:0] RST_SP_LOW = 8'h07;
  localparam logic [7:0] RST_DP_EXT = 8'h01;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // value returned for unimplemented or write-only locations
  localparam logic [7:0] RD_UNIMPL = 8'h00;

  // register file view of the dedicated bytes
  typedef enum logic [2:0] {
    RF_ACC = 3'h0,
    RF_MULT_B = 3'h1,
    RF_SP_LOW = 3'h2,
    RF_SP_HIGH = 3'h3,
    RF_DP_LOW = 3'h4,
    RF_DP_HIGH = 3'h5,
    RF_DP_EXT = 3'h6
  } ssd_rfsel_t;

endpackage : ssd_pkg
`default_nettype wire
